// ==== src/timer_defines.vh ====
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// byte register word addresses (wishbone address bits 5:2, one word each)
`define REG_CLOCK_RUN 4'h0
`define REG_MODE_OUT 4'h1
`define REG_CNT_LOW 4'h2
`define REG_CNT_HIGH 4'h3
`define REG_CMP_A_LOW 4'h4
`define REG_CMP_A_HIGH 4'h5
`define REG_CMP_P 4'h6
`define REG_FLAGS 4'h7
// control register 0 fields
`define F_PAUSE 7
`define F_CLKSEL_HI 6
`define F_CLKSEL_LO 4
`define F_MODULE_ON 3
// control register 1 fields
`define F_MODE_HI 7
`define F_MODE_LO 6
`define F_FUNC_HI 5
`define F_FUNC_LO 4
`define F_INIT_LEVEL 3
`define F_INVERT 2
`define F_SWAP 1
`define F_CLR_SRC 0
// flags register fields
`define F_FLAG_A 0
`define F_FLAG_P 1
// reset values
`define RST_BYTE 8'h00
// modes
`define MODE_COMPARE 2'b00
`define MODE_CAPTURE 2'b01
`define MODE_PWM 2'b10
`define MODE_COUNTER 2'b11
// clock selections
`define CLK_SYS_DIV4 3'b000
`define CLK_SYS 3'b001
`define CLK_HIGH_DIV16 3'b010
`define CLK_HIGH_DIV64 3'b011
`define CLK_SUB 3'b100
`define CLK_RESERVED 3'b101
`define CLK_PIN_RISE 3'b110
`define CLK_PIN_FALL 3'b111
// prescaler counts
`define DIV4_LAST 6'h03
`define DIV16_LAST 6'h0f
`define DIV64_LAST 6'h3f
`endif

// ==== src/pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; level accepted once stages two and three agree
module pin_sync (
    input wire clock_i,
    input wire reset_i,
    input wire pin_i,
    output reg level_o
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // s1 feeds only s2, metastability stays contained
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_o <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end
endmodule // pin_sync
`default_nettype wire

// ==== src/standard_timer_module_regs.v ====
// Behaviour
// - pause bit set holds counter value; clearing resumes from held value
// - clock select chooses sys/4, sys, high/16, high/64, sub, pin edges; 101 stops
// - on bit runs counter; off stops it and keeps residual value
// - rising edge of on bit clears counter to zero
// - compare mode: on-bit rising edge returns pin to initial level
// - low three bits of control register 0 read zero
// - mode field: compare, capture, pwm/single pulse, timer/counter
// - compare mode A match: none, low, high, toggle
// - pwm mode function: inactive, active, pwm, single pulse
// - capture mode edge: rising, falling, both, disabled
// - output control sets initial level or active level; unused in counter mode
// - invert bit inverts output pin; unused in counter mode
// - swap bit chooses which compare value is period and which duty
// - clear select: A match, or P match / overflow when P is zero
// - clear select ignored in pwm, single pulse and capture modes
// - counter readable as read-only low and high bytes
// - compare A held in read/write low and high bytes
// - P value compared with counter high byte; zero means 65536 clocks
// - counter cleared by A matches through clear select raises no P match flag
// - compare mode: only A matches alter the output pin
// - pwm duty at or above period gives continuous active output
`include "timer_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module standard_timer_module_regs (
    input wire clock_i,
    input wire reset_i,
    // wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [5:2] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // clock sources and pins
    input wire high_speed_tick_i,
    input wire sub_clock_tick_i,
    input wire external_clock_pin_i,
    input wire timer_io_pin_i,
    output reg timer_io_pin_o,
    output wire timer_io_pin_oe_n_o,
    output reg compare_a_flag_o,
    output reg compare_p_flag_o,
    output reg capture_event_o
);
    reg [7:0] ctrl0_q;
    reg [7:0] ctrl1_q;
    reg [15:0] compare_a_value_q;
    reg [7:0] compare_p_value_q;
    reg [15:0] count_q;
    reg [15:0] capture_q;
    reg [5:0] sys_pre_q;
    reg [5:0] high_pre_q;
    reg on_prev_q;
    reg pin_level_q;
    reg ack_q;
    reg ext_prev_q;
    reg io_prev_q;
    reg pulse_q;
    wire ext_level;
    wire io_level;

    wire counter_pause = ctrl0_q[`F_PAUSE];
    wire [2:0] counter_clock_select = ctrl0_q[`F_CLKSEL_HI:`F_CLKSEL_LO];
    wire module_on = ctrl0_q[`F_MODULE_ON];
    wire [1:0] operating_mode_select = ctrl1_q[`F_MODE_HI:`F_MODE_LO];
    wire [1:0] output_function_select = ctrl1_q[`F_FUNC_HI:`F_FUNC_LO];
    wire output_initial_level = ctrl1_q[`F_INIT_LEVEL];
    wire output_invert = ctrl1_q[`F_INVERT];
    wire period_duty_swap = ctrl1_q[`F_SWAP];
    wire clear_source_select = ctrl1_q[`F_CLR_SRC];

    // byte lane 0 carries every register except flags (capture in bits 15:0, pin level in bit 16); other bits read zero
    wire bus_req = wb_cyc_i & wb_stb_i;
    wire bus_wr = bus_req & wb_we_i & ~ack_q & wb_sel_i[0];

    // address decode shared by write and read paths
    function is_reg;
        input [3:0] adr;
        input [3:0] which;
        begin
            is_reg = (adr == which);
        end
    endfunction

    pin_sync ext_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .pin_i(external_clock_pin_i),
        .level_o(ext_level)
    );

    pin_sync io_sync (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .pin_i(timer_io_pin_i),
        .level_o(io_level)
    );

    // one-cycle ack, dropped the cycle after it is given
    assign wb_ack_o = ack_q;
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    // register writes; unmapped addresses accept and ignore
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl0_q <= `RST_BYTE;
            ctrl1_q <= `RST_BYTE;
            compare_a_value_q <= {`RST_BYTE, `RST_BYTE};
            compare_p_value_q <= `RST_BYTE;
        end else if (bus_wr) begin
            if (is_reg(wb_adr_i, `REG_CLOCK_RUN)) begin
                ctrl0_q <= {wb_dat_i[7:3], 3'b000};
            end else if (is_reg(wb_adr_i, `REG_MODE_OUT)) begin
                ctrl1_q <= wb_dat_i[7:0];
            end else if (is_reg(wb_adr_i, `REG_CMP_A_LOW)) begin
                compare_a_value_q[7:0] <= wb_dat_i[7:0];
            end else if (is_reg(wb_adr_i, `REG_CMP_A_HIGH)) begin
                compare_a_value_q[15:8] <= wb_dat_i[7:0];
            end else if (is_reg(wb_adr_i, `REG_CMP_P)) begin
                compare_p_value_q <= wb_dat_i[7:0];
            end
        end
    end

    // read mux, registered so data and ack line up
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req & ~ack_q) begin
            wb_dat_o <= 32'h00000000;
            if (is_reg(wb_adr_i, `REG_CLOCK_RUN)) begin
                wb_dat_o[7:0] <= ctrl0_q;
            end else if (is_reg(wb_adr_i, `REG_MODE_OUT)) begin
                wb_dat_o[7:0] <= ctrl1_q;
            end else if (is_reg(wb_adr_i, `REG_CNT_LOW)) begin
                wb_dat_o[7:0] <= count_q[7:0];
            end else if (is_reg(wb_adr_i, `REG_CNT_HIGH)) begin
                wb_dat_o[7:0] <= count_q[15:8];
            end else if (is_reg(wb_adr_i, `REG_CMP_A_LOW)) begin
                wb_dat_o[7:0] <= compare_a_value_q[7:0];
            end else if (is_reg(wb_adr_i, `REG_CMP_A_HIGH)) begin
                wb_dat_o[7:0] <= compare_a_value_q[15:8];
            end else if (is_reg(wb_adr_i, `REG_CMP_P)) begin
                wb_dat_o[7:0] <= compare_p_value_q;
            end else if (is_reg(wb_adr_i, `REG_FLAGS)) begin
                wb_dat_o[15:0] <= capture_q;
                wb_dat_o[16] <= pin_level_q;
            end
        end
    end

    // free-running prescalers for the divided internal clocks
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            sys_pre_q <= 6'h00;
            high_pre_q <= 6'h00;
            ext_prev_q <= 1'b0;
            io_prev_q <= 1'b0;
        end else begin
            sys_pre_q <= (sys_pre_q == `DIV4_LAST) ? 6'h00 : sys_pre_q + 6'h01;
            if (high_speed_tick_i) begin
                high_pre_q <= high_pre_q + 6'h01;
            end
            ext_prev_q <= ext_level;
            io_prev_q <= io_level;
        end
    end

    // clock event selection; reserved gives no events
    reg tick;
    always @* begin
        tick = 1'b0;
        case (counter_clock_select)
            `CLK_SYS_DIV4: tick = (sys_pre_q == `DIV4_LAST);
            `CLK_SYS: tick = 1'b1;
            `CLK_HIGH_DIV16: tick = high_speed_tick_i & (high_pre_q[3:0] == `DIV16_LAST);
            `CLK_HIGH_DIV64: tick = high_speed_tick_i & (high_pre_q == `DIV64_LAST);
            `CLK_SUB: tick = sub_clock_tick_i;
            `CLK_PIN_RISE: tick = ext_level & ~ext_prev_q;
            `CLK_PIN_FALL: tick = ~ext_level & ext_prev_q;
            default: tick = 1'b0;
        endcase
    end

    wire on_rise = module_on & ~on_prev_q;
    // counting gated by on and pause
    wire run = module_on & ~counter_pause & tick;
    wire is_pwm = (operating_mode_select == `MODE_PWM);
    wire is_cmp = (operating_mode_select == `MODE_COMPARE);
    wire is_cap = (operating_mode_select == `MODE_CAPTURE);
    // P compares with counter high byte at the end of its span
    wire p_match = run & (compare_p_value_q != 8'h00) &
        (count_q == {compare_p_value_q - 8'h01, 8'hff});
    wire a_match = run & (compare_a_value_q != 16'h0000) &
        (count_q == compare_a_value_q - 16'h0001);
    wire overflow = run & (count_q == 16'hffff);
    // swap picks which comparator ends the period
    wire pwm_clear = period_duty_swap ? a_match : (p_match | (compare_p_value_q == 8'h00 & overflow));
    // clear source, pwm uses period comparator instead
    wire clr_a_src = ~is_pwm & ~is_cap & clear_source_select;
    wire cnt_clear = is_pwm ? pwm_clear :
        (clr_a_src ? a_match : (p_match | (compare_p_value_q == 8'h00 & overflow)));
    wire [16:0] period_len = period_duty_swap ? {1'b0, compare_a_value_q} :
        ((compare_p_value_q == 8'h00) ? 17'h10000 : {1'b0, compare_p_value_q, 8'h00});
    wire [16:0] duty_len = period_duty_swap ?
        ((compare_p_value_q == 8'h00) ? 17'h10000 : {1'b0, compare_p_value_q, 8'h00}) :
        {1'b0, compare_a_value_q};
    // duty at or above period stays active
    wire pwm_active = (duty_len >= period_len) | ({1'b0, count_q} < duty_len);

    // counter increments and wraps; on-edge clears
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= 16'h0000;
            on_prev_q <= 1'b0;
        end else begin
            on_prev_q <= module_on;
            if (on_rise) begin
                count_q <= 16'h0000;
            end else if (cnt_clear) begin
                count_q <= 16'h0000;
            end else if (run) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end

    // match flags as one-cycle pulses
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            compare_a_flag_o <= 1'b0;
            compare_p_flag_o <= 1'b0;
        end else begin
            compare_a_flag_o <= a_match;
            // no P flag when clear select has A clear the counter
            compare_p_flag_o <= p_match & ~clr_a_src;
        end
    end

    // capture edge choice, holds counter value
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            capture_q <= 16'h0000;
            capture_event_o <= 1'b0;
        end else begin
            capture_event_o <= 1'b0;
            if (operating_mode_select == `MODE_CAPTURE && module_on) begin
                if ((output_function_select == 2'b00 && io_level && !io_prev_q) ||
                    (output_function_select == 2'b01 && !io_level && io_prev_q) ||
                    (output_function_select == 2'b10 && io_level != io_prev_q)) begin
                    capture_q <= count_q;
                    capture_event_o <= 1'b1;
                end
            end
        end
    end

    // compare-mode pin level and single pulse state
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pin_level_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            // on rising edge restores initial level
            if (on_rise) begin
                pin_level_q <= output_initial_level;
            // only A matches change the pin
            end else if (is_cmp && a_match) begin
                case (output_function_select)
                    2'b01: pin_level_q <= 1'b0;
                    2'b10: pin_level_q <= 1'b1;
                    2'b11: pin_level_q <= ~pin_level_q;
                    default: pin_level_q <= pin_level_q;
                endcase
            end
            // single pulse: leading edge at on rise, trailing at A match or off
            if (on_rise) begin
                pulse_q <= 1'b1;
            end else if (!module_on || a_match) begin
                pulse_q <= 1'b0;
            end
        end
    end

    reg pwm_level;
    always @* begin
        case (output_function_select)
            2'b00: pwm_level = ~output_initial_level;
            2'b01: pwm_level = output_initial_level;
            2'b10: pwm_level = module_on & pwm_active ? output_initial_level : ~output_initial_level;
            default: pwm_level = pulse_q ? output_initial_level : ~output_initial_level;
        endcase
    end

    // inversion applies in every mode; registered pin
    // pin released in counter and capture modes
    assign timer_io_pin_oe_n_o = ~(is_cmp | is_pwm);
    always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            timer_io_pin_o <= 1'b0;
        end else begin
            timer_io_pin_o <= (is_pwm ? pwm_level : pin_level_q) ^ output_invert;
        end
    end
endmodule // standard_timer_module_regs
`default_nettype wire

// ==== verif/timer_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module timer_monitor (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:2] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic timer_io_pin_o,
    input wire logic timer_io_pin_oe_n_o,
    input wire logic compare_p_flag_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [7:0] shadow_q [0:7];
    logic [1:0] calm_q;
    wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    wire rd = wb_ack_o && !wb_we_i;
    wire settled = calm_q == 2'd3;
    wire [7:0] c0 = shadow_q[0];
    wire [7:0] c1 = shadow_q[1];
    // shadow of acked writes; calm lets registered outputs catch up after a control write
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 8; i++)
                shadow_q[i] <= 8'h00;
            calm_q <= 2'd0;
        end else begin
            if (wr && !wb_adr_i[5])
                shadow_q[wb_adr_i[4:2]] <= wb_dat_i[7:0];
            if (wr && wb_adr_i[5:3] == 3'b000)
                calm_q <= 2'd0;
            else if (!settled)
                calm_q <= calm_q + 2'd1;
        end
    end

    ack_follows_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    ctrl0_low_zero_a: assert property (
        rd && wb_adr_i == `REG_CLOCK_RUN |-> wb_dat_o == {24'h000000, c0[7:3], 3'h0})
        else $error("control 0 readback wrong");
    rw_readback_a: assert property (
        rd && (wb_adr_i[5:3] == 3'h2 || wb_adr_i == `REG_MODE_OUT || wb_adr_i == `REG_CMP_P)
        |-> wb_dat_o == {24'h000000, shadow_q[wb_adr_i[4:2]]})
        else $error("register readback wrong");
    unmapped_zero_a: assert property (rd && wb_adr_i[5] |-> wb_dat_o == 32'h00000000)
        else $error("unmapped read not zero");
    pin_enable_a: assert property (settled |-> timer_io_pin_oe_n_o == c1[6])
        else $error("pin enable wrong for mode");
    pwm_forced_a: assert property (
        settled && c0[3] && c1[7:6] == `MODE_PWM && !c1[5]
        |-> timer_io_pin_o == ((c1[4] ~^ c1[3]) ^ c1[2]))
        else $error("forced pwm level wrong");
    clr_a_no_p_a: assert property (
        settled && c1[0] && (c1[7:6] == `MODE_COMPARE || c1[7:6] == `MODE_COUNTER)
        |-> !compare_p_flag_o)
        else $error("p flag while clearing on a");
    on_rise_init_a: assert property (
        wr && wb_adr_i == `REG_CLOCK_RUN && wb_dat_i[3] && !c0[3] && c1[7:6] == `MODE_COMPARE
        |-> ##[1:3] timer_io_pin_o == (c1[3] ^ c1[2]))
        else $error("pin not at initial level");
    cover property (wr && wb_adr_i == `REG_CMP_A_LOW);
    cover property (settled && c0[3] && c1[7:6] == `MODE_PWM);
    cover property (compare_p_flag_o);
endmodule // timer_monitor

bind standard_timer_module_regs timer_monitor u_mon (.clock_i, .reset_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .timer_io_pin_o, .timer_io_pin_oe_n_o, .compare_p_flag_o);
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer_defines.vh"
module tb_top;
    logic clock_i = 1'b0, reset_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [5:2] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0;
    logic high_speed_tick_i = 1'b0, sub_clock_tick_i = 1'b0;
    logic external_clock_pin_i = 1'b0, timer_io_pin_i = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, timer_io_pin_o, timer_io_pin_oe_n_o;
    wire compare_a_flag_o, compare_p_flag_o, capture_event_o;
    logic [4:0] div_q = 5'h00;
    logic [15:0] hi, chg, fa, fp, cp;
    int bad_count = 0;
    int comparisons = 0;

    standard_timer_module_regs u_dut (.clock_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .high_speed_tick_i,
        .sub_clock_tick_i, .external_clock_pin_i, .timer_io_pin_i, .timer_io_pin_o,
        .timer_io_pin_oe_n_o, .compare_a_flag_o, .compare_p_flag_o, .capture_event_o);

    // 50 MHz clock
    initial begin
        forever #10 clock_i = ~clock_i;
    end

    // slow clock sources; pins move well below the sync rate so no edge is lost
    always @(posedge clock_i) begin
        div_q <= div_q + 5'h01;
        high_speed_tick_i <= div_q[0];
        sub_clock_tick_i <= div_q[2:0] == 3'h7;
        external_clock_pin_i <= div_q[2];
        timer_io_pin_i <= div_q[4];
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
        output logic [7:0] q);
        int n;
        @(posedge clock_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h000000, d};
        n = 0;
        // no wait limit here; only the watchdog ends a hung cycle
        while (wb_ack_o !== 1'b1) begin
            @(posedge clock_i);
            n++;
        end
        chk("ack wait cycles", 16'h0002, n[15:0]);
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask

    // off before mode or function change
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(`REG_CLOCK_RUN, 8'h00);
        wr(`REG_MODE_OUT, c1);
        wr(`REG_CLOCK_RUN, c0);
        repeat (8) @(posedge clock_i);
    endtask

    // count pin high cycles, pin changes and flag pulses over 512 cycles
    task automatic run(input logic [7:0] c1);
        logic last;
        start(c1, 8'h18);
        {hi, chg, fa, fp} = 64'h0;
        cp = 16'h0000;
        last = timer_io_pin_o;
        repeat (512) begin
            @(posedge clock_i);
            hi += timer_io_pin_o;
            chg += timer_io_pin_o != last;
            last = timer_io_pin_o;
            fa += compare_a_flag_o;
            fp += compare_p_flag_o;
            cp += capture_event_o;
        end
    endtask

    task automatic t_regs();
        logic [7:0] q;
        logic [7:0] ex [10] = '{8'hf8, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00,
            8'h00};
        for (int a = 0; a < 8; a++) begin
            rd(a[3:0], q);
            chk("reset value", 16'h0000, q);
        end
        for (int a = 0; a < 10; a++)
            wr(a[3:0], 8'hff);
        wb_sel_i <= 4'h0;
        wr(`REG_CMP_P, 8'h00);
        wb_sel_i <= 4'h1;
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0], q);
            chk("readback", ex[a], q);
        end
        $display("register test done");
    endtask

    task automatic t_count();
        logic [7:0] a, b;
        wr(`REG_CMP_P, 8'h00);
        // counter mode with pin function left at 00
        start(8'hc0, 8'h18);
        rd(`REG_CNT_LOW, a);
        rd(`REG_CNT_LOW, b);
        chk("count step", 16'h0003, b - a);
        wr(`REG_CLOCK_RUN, 8'h98);
        rd(`REG_CNT_LOW, a);
        rd(`REG_CNT_LOW, b);
        chk("paused count", a, b);
        wr(`REG_CLOCK_RUN, 8'h18);
        rd(`REG_CNT_LOW, b);
        chk("resumed count", 16'h0001, b > a && b - a < 8'h08);
        wr(`REG_CLOCK_RUN, 8'h10);
        rd(`REG_CNT_LOW, a);
        repeat (20) @(posedge clock_i);
        rd(`REG_CNT_LOW, b);
        chk("count while off", a, b);
        chk("residual kept", 16'h0001, a != 8'h00);
        rd(`REG_CNT_HIGH, b);
        chk("count high byte", 16'h0000, b);
        wr(`REG_CLOCK_RUN, 8'h18);
        rd(`REG_CNT_LOW, a);
        chk("count after restart", 16'h0001, a < 8'h08);
        $display("count test done");
    endtask

    task automatic t_clk();
        logic [7:0] q;
        for (int s = 0; s < 8; s++) begin
            wr(`REG_CLOCK_RUN, 8'h00);
            wr(`REG_CLOCK_RUN, {1'b0, s[2:0], 4'h8});
            repeat (200) @(posedge clock_i);
            rd(`REG_CNT_LOW, q);
            chk("counter moved", s != 5, q != 8'h00);
        end
        $display("clock select test done");
    endtask

    task automatic t_pwm();
        logic [7:0] c1 [6] = '{8'ha8, 8'hac, 8'ha8, 8'haa, 8'h88, 8'h98};
        logic [7:0] ah [6] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h02};
        logic [7:0] al [6] = '{8'h40, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [15:0] ex [6] = '{16'h0080, 16'h0180, 16'h0200, 16'h0100, 16'h0000, 16'h0200};
        wr(`REG_CMP_P, 8'h01);
        for (int i = 0; i < 6; i++) begin
            wr(`REG_CMP_A_HIGH, ah[i]);
            wr(`REG_CMP_A_LOW, al[i]);
            run(c1[i]);
            chk("pwm high cycles", ex[i], hi);
        end
        $display("pwm test done");
    endtask

    task automatic t_cmp();
        logic [7:0] c1 [7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h30, 8'h35, 8'h29};
        logic [15:0] ce [7] = '{16'h0, 16'h0, 16'h1, 16'h10, 16'h2, 16'h10, 16'h0};
        wr(`REG_CMP_P, 8'h01);
        wr(`REG_CMP_A_HIGH, 8'h00);
        wr(`REG_CMP_A_LOW, 8'h20);
        for (int i = 0; i < 7; i++) begin
            run(c1[i]);
            chk("pin changes", ce[i], chg);
            chk("a flags", c1[i][0] ? 16'h0010 : 16'h0002, fa);
            chk("p flags", c1[i][0] ? 16'h0000 : 16'h0002, fp);
        end
        // counter passes the P value while A clears it: P flag stays quiet
        wr(`REG_CMP_A_HIGH, 8'h02);
        wr(`REG_CMP_A_LOW, 8'h00);
        run(8'h01);
        chk("a flags long", 16'h0001, fa);
        chk("p flags masked", 16'h0000, fp);
        $display("compare test done");
    endtask

    // capture pin toggles every 16 cycles: 16 rises and 16 falls per window
    task automatic t_cap();
        logic [7:0] c1 [4] = '{8'h41, 8'h51, 8'h61, 8'h71};
        logic [15:0] ex [4] = '{16'h0010, 16'h0010, 16'h0020, 16'h0000};
        for (int i = 0; i < 4; i++) begin
            run(c1[i]);
            chk("capture events", ex[i], cp);
        end
        $display("capture test done");
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // whole run needs about 11400 cycles
    initial begin
        repeat (30000) @(posedge clock_i);
        bad_count++;
        $display("BAD watchdog expected finish seen timeout");
        summarize();
    end

    initial begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        t_regs();
        t_count();
        t_clk();
        t_pwm();
        t_cmp();
        t_cap();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
